// ==== hdl/cbgc_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "cbgc_map.svh"
module cbgc_regs #(
    parameter int PINS = 4,
    parameter logic [1:0] XTAL_DEFAULT = `CBGC_DEF_XTAL
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Reset pin and straps
    input wire logic async_reset_pin_n,
    input wire logic test_strap,
    input wire logic [1:0] autoconfig_strap,
    // General-purpose pins
    input wire logic [PINS-1:0] gpio_in,
    output logic [PINS-1:0] gpio_out,
    output logic [PINS-1:0] gpio_oe,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`CBGC_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rdata_valid,
    // EEPROM port
    output logic ee_wr,
    output logic ee_rd,
    output logic [`CBGC_ADDR_W-1:0] ee_addr,
    output logic [7:0] ee_wdata,
    input wire logic [7:0] ee_rdata,
    // Mode and control outputs and switch enable input
    output logic direct_write_mode,
    output logic miso_force_drive,
    output logic function_reset,
    output logic [1:0] crystal_pin_mode,
    output logic [2:0] input_clock_enables,
    output logic [2:0] output_clock_enables,
    input wire logic external_switch_enable,
    output logic ext_switch_control,
    output logic irq_request
);
    logic rpin_lvl;
    logic test_lvl;
    logic [1:0] ac_lvl;
    logic [PINS-1:0] pin_lvl;
    logic rpin_prev;
    logic rpin_rise;
    logic pin_rst;
    logic soft_rst;
    logic cfg_rst;
    logic bank_sel;
    logic latched_test;
    logic [1:0] latched_ac;
    logic [1:0] ext_src;
    logic [3:0] pin_cfg [PINS];
    logic [7:0] pin_ss [PINS];
    logic [PINS-1:0] pin_prev;
    logic [PINS-1:0] edge_stat;
    logic [PINS-1:0] edge_en;
    logic [PINS-1:0] next_edge_stat;
    logic [PINS-1:0] pin_logic;
    logic in_range;
    logic dev_sel;
    logic ee_sel;
    logic dev_wr;
    logic ee_rd_pend;
    logic [7:0] dev_rdata;
    logic [7:0] cfg_stat;

    cbgc_pin_sync #(
        .W(PINS + 4)
    ) u_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .pin_async({gpio_in, autoconfig_strap, test_strap,
            async_reset_pin_n}),
        .pin_level({pin_lvl, ac_lvl, test_lvl, rpin_lvl})
    );

    assign pin_rst = ~rpin_lvl;
    assign rpin_rise = rpin_lvl & ~rpin_prev;
    assign cfg_rst = srst | pin_rst | soft_rst; // R11 R14

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rpin_prev <= 1'b0;
        end else begin
            rpin_prev <= rpin_lvl;
        end
    end

    // Straps are caught at the release only; soft reset leaves them alone
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            latched_test <= 1'b0;
            latched_ac <= 2'h0;
        end else if (rpin_rise) begin // R15
            latched_test <= test_lvl;
            latched_ac <= ac_lvl;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            direct_write_mode <= 1'b0;
        end else if (rpin_rise) begin
            if (!test_lvl) begin
                direct_write_mode <= 1'b0; // R3
            end else if (ac_lvl == `CBGC_AC_DIRECT) begin
                direct_write_mode <= 1'b1; // R1
            end
        end
    end

    assign miso_force_drive = direct_write_mode; // R4

    // Address decode
    assign in_range = reg_addr <= `CBGC_ADDR_LAST; // R5
    assign dev_sel = in_range && !direct_write_mode &&
        (reg_addr == `CBGC_OFS_BANK || !bank_sel); // R2 R12
    assign ee_sel = in_range && (direct_write_mode ||
        (bank_sel && reg_addr != `CBGC_OFS_BANK)); // R2 R12
    assign dev_wr = reg_wr && dev_sel;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ee_wr <= 1'b0;
            ee_rd <= 1'b0;
            ee_addr <= '0;
            ee_wdata <= 8'h00;
        end else begin
            ee_wr <= reg_wr && ee_sel;
            ee_rd <= reg_rd && ee_sel;
            ee_addr <= reg_addr;
            ee_wdata <= reg_wdata;
        end
    end

    // Soft reset bit survives its own reset; the pin, srst or a host write of zero clear it
    always_ff @(posedge sys_clk) begin
        if (srst || pin_rst) begin
            soft_rst <= 1'b0;
            bank_sel <= 1'b0;
        end else if (dev_wr && reg_addr == `CBGC_OFS_MCFG1) begin
            soft_rst <= reg_wdata[`CBGC_BIT_SOFT]; // R14
        end else if (dev_wr && reg_addr == `CBGC_OFS_BANK) begin
            bank_sel <= reg_wdata[`CBGC_BIT_BANK]; // R12
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            function_reset <= 1'b1;
        end else begin
            function_reset <= pin_rst | soft_rst; // R14
        end
    end

    always_ff @(posedge sys_clk) begin
        if (cfg_rst) begin // R11 R14
            crystal_pin_mode <= XTAL_DEFAULT;
            ext_src <= `CBGC_DEF_EXT_SRC;
            input_clock_enables <= `CBGC_DEF_IN_EN;
            output_clock_enables <= `CBGC_DEF_OUT_EN;
        end else if (dev_wr) begin
            if (reg_addr == `CBGC_OFS_MCFG1) begin
                crystal_pin_mode <= reg_wdata[1:0]; // R16
            end
            if (reg_addr == `CBGC_OFS_MCFG2) begin
                ext_src <= reg_wdata[6:5]; // R17
            end
            if (reg_addr == `CBGC_OFS_IN_EN) begin
                input_clock_enables <= reg_wdata[2:0]; // R18
            end
            if (reg_addr == `CBGC_OFS_OUT_EN) begin
                output_clock_enables <= reg_wdata[2:0]; // R19
            end
        end
    end

    for (genvar i = 0; i < PINS; i++) begin : g_pin_regs
        localparam logic [`CBGC_ADDR_W-1:0] CFG_OFS =
            `CBGC_OFS_PCFG_LO + `CBGC_ADDR_W'(i / 2);
        localparam logic [`CBGC_ADDR_W-1:0] SS_OFS =
            `CBGC_OFS_PSS0 + `CBGC_ADDR_W'(i);
        always_ff @(posedge sys_clk) begin
            if (cfg_rst) begin
                pin_cfg[i] <= `CBGC_DEF_PCFG;
                pin_ss[i] <= `CBGC_DEF_PSS;
            end else if (dev_wr) begin
                if (reg_addr == CFG_OFS) begin
                    pin_cfg[i] <= reg_wdata[(i % 2) * 4 +: 4]; // R21
                end
                if (reg_addr == SS_OFS) begin
                    pin_ss[i] <= reg_wdata;
                end
            end
        end
    end

    // Latched pin edges; a new edge beats a clear in the same cycle
    always_comb begin
        next_edge_stat = edge_stat;
        if (dev_wr && reg_addr == `CBGC_OFS_EDGE_STAT) begin
            next_edge_stat = edge_stat & ~reg_wdata[PINS-1:0]; // R9
        end
        next_edge_stat = next_edge_stat | (pin_lvl & ~pin_prev); // R9
    end

    always_ff @(posedge sys_clk) begin
        if (cfg_rst) begin
            edge_stat <= '0;
            edge_en <= `CBGC_DEF_EDGE_EN;
            pin_prev <= pin_lvl;
            irq_request <= 1'b0;
        end else begin
            edge_stat <= next_edge_stat;
            pin_prev <= pin_lvl;
            irq_request <= |(edge_stat & edge_en); // R10
            if (dev_wr && reg_addr == `CBGC_OFS_EDGE_EN) begin
                edge_en <= reg_wdata[PINS-1:0];
            end
        end
    end

    assign cfg_stat = {latched_test, 5'h00, latched_ac};

    // Only implemented status bits are nonzero; pin levels never follow
    function automatic logic status_bit(input logic [7:0] sel);
        logic [7:0] stat_byte;
        stat_byte = 8'h00;
        unique case (sel[7:3]) // R22
            `CBGC_IDX_CFG_STAT: stat_byte = cfg_stat;
            `CBGC_IDX_EDGE_STAT: stat_byte = 8'(edge_stat);
            `CBGC_IDX_IRQ_STAT: stat_byte = {7'h00, irq_request};
            default: stat_byte = 8'h00; // R22 R24
        endcase
        return stat_byte[sel[2:0]]; // R23
    endfunction

    for (genvar i = 0; i < PINS; i++) begin : g_pin_drive
        logic stat;
        assign stat = status_bit(pin_ss[i]);
        assign pin_logic[i] =
            pin_lvl[i] ^ (pin_cfg[i] == cbgc_pkg::CBGC_PIN_IN_INV);
        always_ff @(posedge sys_clk) begin
            if (cfg_rst) begin
                gpio_out[i] <= 1'b0;
                gpio_oe[i] <= 1'b0;
            end else begin
                unique case (pin_cfg[i]) // R20
                    cbgc_pkg::CBGC_PIN_OUT_LOW: begin
                        gpio_out[i] <= 1'b0;
                        gpio_oe[i] <= 1'b1;
                    end
                    cbgc_pkg::CBGC_PIN_OUT_HIGH: begin
                        gpio_out[i] <= 1'b1;
                        gpio_oe[i] <= 1'b1;
                    end
                    cbgc_pkg::CBGC_PIN_STAT: begin
                        gpio_out[i] <= stat;
                        gpio_oe[i] <= 1'b1;
                    end
                    cbgc_pkg::CBGC_PIN_STAT_INV: begin
                        gpio_out[i] <= ~stat;
                        gpio_oe[i] <= 1'b1;
                    end
                    cbgc_pkg::CBGC_PIN_STAT_LOW_Z: begin
                        gpio_out[i] <= 1'b0;
                        gpio_oe[i] <= ~stat;
                    end
                    cbgc_pkg::CBGC_PIN_STAT_Z_LOW: begin
                        gpio_out[i] <= 1'b0;
                        gpio_oe[i] <= stat;
                    end
                    // Inputs and unused codes leave the pin floating
                    default: begin
                        gpio_out[i] <= 1'b0;
                        gpio_oe[i] <= 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (cfg_rst) begin
            ext_switch_control <= 1'b0;
        end else begin
            ext_switch_control <=
                external_switch_enable & pin_logic[ext_src]; // R17
        end
    end

    // Read mux; write-only bank select reads as zero, read-only fields ignore writes
    always_comb begin
        dev_rdata = 8'h00;
        unique case (reg_addr)
            `CBGC_OFS_BANK: dev_rdata = 8'h00; // R13
            `CBGC_OFS_MCFG1: dev_rdata = {soft_rst, 5'h00, crystal_pin_mode};
            `CBGC_OFS_MCFG2: dev_rdata = {1'b0, ext_src, 5'h00};
            `CBGC_OFS_IN_EN: dev_rdata = {5'h00, input_clock_enables};
            `CBGC_OFS_OUT_EN: dev_rdata = {5'h00, output_clock_enables};
            `CBGC_OFS_PCFG_LO: dev_rdata = {pin_cfg[1], pin_cfg[0]};
            `CBGC_OFS_PCFG_HI: dev_rdata = {pin_cfg[3], pin_cfg[2]};
            `CBGC_OFS_PSS0: dev_rdata = pin_ss[0];
            `CBGC_OFS_PSS0 + 11'h001: dev_rdata = pin_ss[1];
            `CBGC_OFS_PSS0 + 11'h002: dev_rdata = pin_ss[2];
            `CBGC_OFS_PSS0 + 11'h003: dev_rdata = pin_ss[3];
            `CBGC_OFS_CFG_STAT: dev_rdata = cfg_stat; // R7
            `CBGC_OFS_PIN_LVL: dev_rdata = 8'(pin_lvl); // R8
            `CBGC_OFS_EDGE_STAT: dev_rdata = 8'(edge_stat);
            `CBGC_OFS_EDGE_EN: dev_rdata = 8'(edge_en);
            `CBGC_OFS_IRQ_STAT: dev_rdata = {7'h00, irq_request};
            default: dev_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
            reg_rdata_valid <= 1'b0;
            ee_rd_pend <= 1'b0;
        end else begin
            ee_rd_pend <= reg_rd && ee_sel;
            reg_rdata_valid <= (reg_rd && !ee_sel) || ee_rd_pend;
            if (ee_rd_pend) begin
                reg_rdata <= ee_rdata;
            end else if (reg_rd) begin
                reg_rdata <= dev_sel ? dev_rdata : 8'h00;
            end
        end
    end

    sequence s_rise_enter;
        rpin_rise && test_lvl && ac_lvl == `CBGC_AC_DIRECT;
    endsequence

    property p_enter;
        @(posedge sys_clk) disable iff (srst)
        s_rise_enter |=> direct_write_mode && miso_force_drive;
    endproperty
    a_enter: assert property (p_enter) // R1 R4
        else $error("direct mode not entered");

    property p_exit;
        @(posedge sys_clk) disable iff (srst)
        rpin_rise && !test_lvl |=> !direct_write_mode;
    endproperty
    a_exit: assert property (p_exit) // R3
        else $error("direct mode not left");

    property p_hold;
        @(posedge sys_clk) disable iff (srst)
        !(rpin_rise && !test_lvl) && direct_write_mode |=> direct_write_mode;
    endproperty
    a_hold: assert property (p_hold) // R3
        else $error("direct mode left without strap");

    property p_direct_ee;
        @(posedge sys_clk) disable iff (srst)
        direct_write_mode && reg_wr && in_range |-> !dev_wr ##1 ee_wr;
    endproperty
    a_direct_ee: assert property (p_direct_ee) // R2
        else $error("direct write not routed to memory");

    property p_unmapped;
        @(posedge sys_clk) disable iff (srst)
        reg_rd && !in_range |=> reg_rdata_valid && reg_rdata == 8'h00 &&
            !ee_rd;
    endproperty
    a_unmapped: assert property (p_unmapped) // R5
        else $error("unmapped read not zero");

    property p_clear_one;
        @(posedge sys_clk) disable iff (srst)
        !cfg_rst && dev_wr && reg_addr == `CBGC_OFS_EDGE_STAT &&
            reg_wdata[0] && !(pin_lvl[0] && !pin_prev[0]) |=> !edge_stat[0];
    endproperty
    a_clear_one: assert property (p_clear_one) // R9
        else $error("write one did not clear");

    property p_keep_zero;
        @(posedge sys_clk) disable iff (srst)
        !cfg_rst && edge_stat[0] && !(dev_wr &&
            reg_addr == `CBGC_OFS_EDGE_STAT && reg_wdata[0]) |=> edge_stat[0];
    endproperty
    a_keep_zero: assert property (p_keep_zero) // R9
        else $error("latched bit lost");

    property p_irq;
        @(posedge sys_clk) disable iff (srst)
        !cfg_rst ##1 !cfg_rst |->
            irq_request == |($past(edge_stat) & $past(edge_en));
    endproperty
    a_irq: assert property (p_irq) // R10
        else $error("interrupt request mismatch");

    property p_soft;
        @(posedge sys_clk) disable iff (srst)
        soft_rst |=> input_clock_enables == `CBGC_DEF_IN_EN &&
            output_clock_enables == `CBGC_DEF_OUT_EN && function_reset &&
            $stable(latched_ac) && $stable(latched_test);
    endproperty
    a_soft: assert property (p_soft) // R14 R15
        else $error("soft reset did not restore defaults");

    property p_drive_low;
        @(posedge sys_clk) disable iff (srst)
        !cfg_rst && pin_cfg[0] == cbgc_pkg::CBGC_PIN_OUT_LOW |=>
            cfg_rst || (gpio_oe[0] && !gpio_out[0]);
    endproperty
    a_drive_low: assert property (p_drive_low) // R20
        else $error("pin not driven low");
endmodule // cbgc_regs
`default_nettype wire

// ==== hdl/cbgc_map.svh ====
// Behaviour
// R1: Reset rise with test=1, autoconfig=00 enters direct
// R2: Direct mode routes accesses to EEPROM, hides registers
// R3: Direct mode left only when test strap 0
// R4: Direct mode drives MISO continuously
// R5: Decode addresses 000h to 6FFh, bit 7 MSB
// R6: Host writes zero to reserved bits and addresses
// R7: Writes to read-only fields are ignored
// R8: Real-time status reads the live source level
// R9: Latched status sets on edge, write-one clears
// R10: Latched status requests interrupt only when enabled
// R11: Reset returns every configuration field to default; soft reset leaves bank select as it was
// R12: Bank select at 0x0 picks registers or EEPROM
// R13: Bank select is write-only, read not reliable
// R14: Soft reset bit holds function and defaults
// R15: Soft reset reloads strap values, no resampling
// R16: Crystal pin mode selects off, crystal, oscillator
// R17: Switch source picks pin, needs switch enable
// R18: Input clock enable bits power inputs 1-3
// R19: Output clock enable bits gate outputs 1-3
// R20: Pin configuration codes decode input, output, status
// R21: Pin config registers hold two pins each
// R22: Status-follow pointer, unimplemented bit drives low
// R23: Three-bit index selects bit within register
// R24: Pin-level status cannot be followed
`ifndef CBGC_MAP_SVH
`define CBGC_MAP_SVH

`define CBGC_ADDR_W 11
`define CBGC_ADDR_LAST 11'h6FF
`define CBGC_OFS_BANK 11'h000
`define CBGC_OFS_MCFG1 11'h009
`define CBGC_OFS_MCFG2 11'h00A
`define CBGC_OFS_IN_EN 11'h00C
`define CBGC_OFS_OUT_EN 11'h00D
`define CBGC_OFS_PCFG_LO 11'h010
`define CBGC_OFS_PCFG_HI 11'h011
`define CBGC_OFS_PSS0 11'h012
`define CBGC_OFS_STAT_BASE 11'h040
`define CBGC_OFS_CFG_STAT 11'h040
`define CBGC_OFS_PIN_LVL 11'h041
`define CBGC_OFS_EDGE_STAT 11'h042
`define CBGC_OFS_EDGE_EN 11'h043
`define CBGC_OFS_IRQ_STAT 11'h044

`define CBGC_IDX_CFG_STAT 5'h00
`define CBGC_IDX_EDGE_STAT 5'h02
`define CBGC_IDX_IRQ_STAT 5'h04

`define CBGC_BIT_BANK 0
`define CBGC_BIT_SOFT 7
`define CBGC_BIT_TEST 7
`define CBGC_AC_DIRECT 2'h0
`define CBGC_DEF_XTAL 2'h0
`define CBGC_DEF_EXT_SRC 2'h3
`define CBGC_DEF_IN_EN 3'h3
`define CBGC_DEF_OUT_EN 3'h7
`define CBGC_DEF_PCFG 4'h0
`define CBGC_DEF_PSS 8'h00
`define CBGC_DEF_EDGE_EN 4'h0

`endif

// ==== hdl/cbgc_pkg.sv ====
package cbgc_pkg;

    typedef enum logic [3:0] {
        CBGC_PIN_IN = 4'h0,
        CBGC_PIN_IN_INV = 4'h1,
        CBGC_PIN_OUT_LOW = 4'h2,
        CBGC_PIN_OUT_HIGH = 4'h3,
        CBGC_PIN_STAT = 4'h4,
        CBGC_PIN_STAT_INV = 4'h5,
        CBGC_PIN_STAT_LOW_Z = 4'h6,
        CBGC_PIN_STAT_Z_LOW = 4'h7
    } cbgc_pin_mode_e;

    typedef logic [7:0] cbgc_byte_t;

endpackage

// ==== hdl/cbgc_pin_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
// Three-stage filter: a change is taken once stages two and three agree
module cbgc_pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Pins and filtered levels
    input wire logic [W-1:0] pin_async,
    output logic [W-1:0] pin_level
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= pin_async;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                pin_level[i] <= 1'b0;
            end else if (stage2[i] == stage3[i]) begin
                pin_level[i] <= stage3[i];
            end
        end
    end
endmodule // cbgc_pin_sync
`default_nettype wire

// ==== testbench/cbgc_ee_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module cbgc_ee_model (
    // Clock
    input wire logic sys_clk,
    // EEPROM port
    input wire logic ee_wr,
    input wire logic ee_rd,
    input wire logic [10:0] ee_addr,
    input wire logic [7:0] ee_wdata,
    output logic [7:0] ee_rdata
);
    logic [7:0] mem [0:255];
    logic [7:0] last;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = ~i[7:0];
        last = 8'h00;
    end
    always @(posedge sys_clk) begin
        if (ee_wr) mem[ee_addr[7:0]] <= ee_wdata;
        if (ee_rd) last <= mem[ee_addr[7:0]];
    end
    // Idle bus shows the inverse, so a stale byte never passes
    assign ee_rdata = ee_rd ? mem[ee_addr[7:0]] : ~last;
endmodule // cbgc_ee_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "cbgc_map.svh"
module tb_top;
    logic sys_clk, srst, async_reset_pin_n, test_strap, reg_wr, reg_rd;
    logic [1:0] autoconfig_strap, crystal_pin_mode;
    logic [3:0] pin_drv, gpio_in, gpio_out, gpio_oe;
    logic [10:0] reg_addr, ee_addr;
    logic [7:0] reg_wdata, reg_rdata, ee_wdata, ee_rdata, v;
    logic reg_rdata_valid, ee_wr, ee_rd, direct_write_mode, miso_force_drive;
    logic function_reset, external_switch_enable, ext_switch_control;
    logic irq_request;
    logic [2:0] input_clock_enables, output_clock_enables;
    int err_total, total_checks;
    localparam logic [10:0] RA [7] = '{`CBGC_OFS_MCFG1, `CBGC_OFS_MCFG2,
        `CBGC_OFS_IN_EN, `CBGC_OFS_OUT_EN, `CBGC_OFS_PCFG_LO,
        `CBGC_OFS_PCFG_HI, `CBGC_OFS_PSS0};
    localparam logic [7:0] DEF [7] = '{8'h00, 8'h60, 8'h03, 8'h07, 8'h00,
        8'h00, 8'h00};
    localparam logic [7:0] MSK [7] = '{8'h03, 8'h60, 8'h07, 8'h07, 8'h77,
        8'h77, 8'hFF};

    // Wire level: design drives where enabled, bench elsewhere
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & pin_drv);

    cbgc_regs DUT (.sys_clk(sys_clk), .srst(srst),
        .async_reset_pin_n(async_reset_pin_n), .test_strap(test_strap),
        .autoconfig_strap(autoconfig_strap), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
        .ee_wr(ee_wr), .ee_rd(ee_rd), .ee_addr(ee_addr),
        .ee_wdata(ee_wdata), .ee_rdata(ee_rdata),
        .direct_write_mode(direct_write_mode),
        .miso_force_drive(miso_force_drive),
        .function_reset(function_reset),
        .crystal_pin_mode(crystal_pin_mode),
        .input_clock_enables(input_clock_enables),
        .output_clock_enables(output_clock_enables),
        .external_switch_enable(external_switch_enable),
        .ext_switch_control(ext_switch_control), .irq_request(irq_request));

    cbgc_ee_model EE (.sys_clk(sys_clk), .ee_wr(ee_wr), .ee_rd(ee_rd),
        .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_rdata(ee_rdata));

    task automatic chk(input string w, input logic [7:0] got,
        input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", w, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #10;
    endtask
    // Strobe lowered, then one idle edge, so calls may follow back to back
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step(1);
        reg_wr = 1'b0;
        step(1);
    endtask
    task automatic rchk(input string w, input logic [10:0] a,
        input logic [7:0] e);
        int i;
        reg_addr = a;
        reg_rd = 1'b1;
        step(1);
        reg_rd = 1'b0;
        for (i = 0; i < 4 && reg_rdata_valid !== 1'b1; i++) step(1);
        chk({w, " valid"}, {7'h0, reg_rdata_valid}, 8'h01);
        chk(w, reg_rdata, e);
        step(2);
    endtask
    task automatic pin_reset(input logic t, input logic [1:0] ac);
        int i;
        async_reset_pin_n = 1'b0;
        test_strap = t;
        autoconfig_strap = ac;
        step(8);
        async_reset_pin_n = 1'b1;
        step(4);
        for (i = 0; i < 20 && function_reset !== 1'b0; i++) step(1);
        chk("reset release", {7'h0, function_reset}, 8'h00);
        step(2);
    endtask
    task automatic done_test(input string w);
        $display("Test %s finished, mismatches so far %0d", w, err_total);
    endtask
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // Whole run is near 300 cycles; 20000 cycles is a hang
    initial begin
        #2_000_000;
        err_total++;
        wrap_up();
    end

    initial begin
        logic [7:0] exp_v [7];
        err_total = 0;
        total_checks = 0;
        srst = 1'b1;
        async_reset_pin_n = 1'b0;
        test_strap = 1'b0;
        autoconfig_strap = 2'h2;
        pin_drv = 4'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 11'h000;
        reg_wdata = 8'h00;
        external_switch_enable = 1'b0;
        void'($urandom(32'h45d387e5));
        step(3);
        srst = 1'b0;
        pin_reset(1'b0, 2'h2);
        for (int i = 0; i < 7; i++) rchk("default", RA[i], DEF[i]);
        for (int i = 0; i < 7; i++) begin
            exp_v[i] = 8'($urandom()) & MSK[i];
            wr(RA[i], exp_v[i]);
        end
        for (int i = 0; i < 7; i++) rchk("rw", RA[i], exp_v[i]);
        chk("inputs", {5'h0, input_clock_enables}, exp_v[2]);
        chk("outputs", {5'h0, output_clock_enables}, exp_v[3]);
        for (int c = 0; c < 4; c++) begin
            wr(`CBGC_OFS_MCFG1, 8'(c));
            chk("xtal", {6'h0, crystal_pin_mode}, 8'(c));
        end
        wr(11'h700, 8'hFF);
        rchk("out of range", 11'h700, 8'h00);
        done_test("registers");

        wr(`CBGC_OFS_PCFG_LO, 8'h00);
        wr(`CBGC_OFS_PCFG_HI, 8'h00);
        pin_drv = 4'($urandom());
        step(6);
        wr(`CBGC_OFS_PIN_LVL, 8'h0F);
        rchk("levels", `CBGC_OFS_PIN_LVL, {4'h0, pin_drv});
        wr(`CBGC_OFS_PCFG_LO, 8'h32);
        chk("drive oe", {4'h0, gpio_oe}, 8'h03);
        chk("drive out", {6'h0, gpio_out[1:0]}, 8'h02);
        wr(`CBGC_OFS_PCFG_LO, 8'h00);
        pin_drv = 4'h0;
        step(6);
        wr(`CBGC_OFS_EDGE_STAT, 8'h0F);
        pin_drv = 4'h5;
        step(6);
        rchk("latched", `CBGC_OFS_EDGE_STAT, 8'h05);
        wr(`CBGC_OFS_EDGE_STAT, 8'h00);
        rchk("write zero", `CBGC_OFS_EDGE_STAT, 8'h05);
        wr(`CBGC_OFS_PSS0 + 11'h001, 8'h10);
        for (int c = 4; c < 8; c++) begin
            wr(`CBGC_OFS_PCFG_LO, 8'(c << 4));
            chk("stat oe", {7'h0, gpio_oe[1]}, {7'h0, c != 6});
            if (c != 6) begin
                chk("stat out", {7'h0, gpio_out[1]}, {7'h0, c == 4});
            end
        end
        wr(`CBGC_OFS_PCFG_LO, 8'h40);
        for (int k = 0; k < 4; k++) begin
            // Bit 2 of edge status is set by pin 2, bit 3 never rose
            wr(`CBGC_OFS_PSS0 + 11'h001, k[1] ? {5'h02, 3'(k)} :
                (k[0] ? 8'h28 : 8'h08));
            v = (k == 2) ? 8'h03 : 8'h02;
            chk("follow", {6'h0, gpio_oe[1], gpio_out[1]}, v);
        end
        done_test("pins");

        wr(`CBGC_OFS_EDGE_EN, 8'h00);
        chk("irq masked", {7'h0, irq_request}, 8'h00);
        wr(`CBGC_OFS_EDGE_EN, 8'h01);
        chk("irq on", {7'h0, irq_request}, 8'h01);
        wr(`CBGC_OFS_EDGE_STAT, 8'h01);
        step(1);
        chk("irq cleared", {7'h0, irq_request}, 8'h00);
        done_test("irq");

        wr(`CBGC_OFS_PCFG_LO, 8'h00);
        external_switch_enable = 1'b1;
        for (int s = 0; s < 4; s++) begin
            wr(`CBGC_OFS_MCFG2, {1'b0, s[1:0], 5'h00});
            pin_drv = 4'($urandom());
            step(6);
            v = {7'h0, pin_drv[s]};
            chk("switch", {7'h0, ext_switch_control}, v);
        end
        external_switch_enable = 1'b0;
        pin_drv = 4'hF;
        step(6);
        chk("switch off", {7'h0, ext_switch_control}, 8'h00);
        done_test("switch");

        wr(`CBGC_OFS_IN_EN, 8'h06);
        wr(`CBGC_OFS_BANK, 8'h01);
        wr(`CBGC_OFS_IN_EN, 8'h5C);
        rchk("eeprom bank", `CBGC_OFS_IN_EN, 8'h5C);
        wr(`CBGC_OFS_BANK, 8'h00);
        rchk("register bank", `CBGC_OFS_IN_EN, 8'h06);
        done_test("bank");

        autoconfig_strap = 2'h1;
        wr(`CBGC_OFS_MCFG1, 8'h80);
        chk("soft reset", {7'h0, function_reset}, 8'h01);
        wr(`CBGC_OFS_IN_EN, 8'h07);
        wr(`CBGC_OFS_MCFG1, 8'h00);
        rchk("soft default", `CBGC_OFS_IN_EN, 8'h03);
        rchk("strap kept", `CBGC_OFS_CFG_STAT, 8'h02);
        done_test("soft reset");

        pin_reset(1'b1, 2'h0);
        chk("direct", {7'h0, direct_write_mode}, 8'h01);
        chk("miso", {7'h0, miso_force_drive}, 8'h01);
        wr(`CBGC_OFS_IN_EN, 8'hC3);
        rchk("direct ee", `CBGC_OFS_IN_EN, 8'hC3);
        chk("hidden", {5'h0, input_clock_enables}, 8'h03);
        pin_reset(1'b1, 2'h1);
        chk("stay", {7'h0, direct_write_mode}, 8'h01);
        pin_reset(1'b0, 2'h2);
        chk("leave", {7'h0, direct_write_mode}, 8'h00);
        chk("miso off", {7'h0, miso_force_drive}, 8'h00);
        rchk("pin default", `CBGC_OFS_IN_EN, 8'h03);
        done_test("direct");
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
